// File: logic/osb_output_slew_boost.sv
// Four-channel output slew limiter and boost supply supervisor.
`timescale 1ns/1ps
module osb_output_slew_boost #(
   parameter int BASE_DIV = osb_pkg::OSB_BASE_TICK_CYC
) (
   // Clock, reset and enable.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clockEnable,
   // Register port.
   input wire logic [osb_pkg::OSB_ADDR_W-1:0] regAddr,
   input wire logic [osb_pkg::OSB_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [osb_pkg::OSB_DATA_W-1:0] regRdData,
   // Clear pin.
   input wire logic clearPin,
   // Output codes to the converters.
   output logic [3:0][osb_pkg::OSB_CODE_W-1:0] outCode,
   output logic [3:0] outEnable,
   // Boost supervision from the analog side.
   input wire logic [3:0][osb_pkg::OSB_DV_W-1:0] loadNeedDv,
   input wire logic [3:0] boostAtCeiling,
   input wire logic [3:0] boostDecayed,
   input wire logic [3:0] boostBelowTarget,
   input wire logic [3:0] lightLoad,
   input wire logic [3:0] switchCurrentLimit,
   // Boost controls to the analog side.
   output logic [3:0][osb_pkg::OSB_DV_W-1:0] boostTargetDv,
   output logic [3:0][osb_pkg::OSB_DV_W-1:0] boostCeilingDv,
   output logic [3:0] switchGate,
   output logic [3:0] boost_limit_flag
);
   import osb_pkg::*;

   localparam int NPIN = 1 + 5 * OSB_NCH;

   logic [11:0] targetCode_ff [OSB_NCH];
   logic [11:0] clearCode_ff [OSB_NCH];
   logic [7:0] slewCfg_ff [OSB_NCH];
   logic [1:0] ctrl_ff [OSB_NCH];
   logic [5:0] boostCfg_ff [OSB_NCH];
   logic [11:0] outCode_ff [OSB_NCH];
   logic [11:0] nxt_target [OSB_NCH];
   logic [11:0] nxt_outCode [OSB_NCH];
   logic [NPIN-1:0] pinSync1_ff;
   logic [NPIN-1:0] pinSync2_ff;
   logic clearPrev_ff;
   logic clearEvent;
   logic [15:0] rdData_ff;
   logic [7:0] baseCnt_ff;
   logic baseTick;
   logic [16:0] tickCnt_ff [OSB_NCH];
   logic [3:0] chTick;
   logic [3:0] busy;
   logic anyBusy;
   osb_bst_t bstState_ff [OSB_NCH];
   logic [5:0] swCnt_ff [OSB_NCH];
   logic [5:0] onCnt_ff [OSB_NCH];
   logic [3:0] gate_ff;
   logic [8:0] bstTarget_ff [OSB_NCH];
   logic [2:0] grp;
   logic [1:0] chSel;

   assign grp = regAddr[4:2];
   assign chSel = regAddr[1:0];

   // Pins from the analog side and the clear pin are asynchronous.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pinSync1_ff <= '0;
         pinSync2_ff <= '0;
         clearPrev_ff <= 1'b0;
      end else if (clockEnable) begin
         pinSync1_ff <= {switchCurrentLimit, lightLoad, boostBelowTarget,
                         boostDecayed, boostAtCeiling, clearPin};
         pinSync2_ff <= pinSync1_ff;
         clearPrev_ff <= pinSync2_ff[0];
      end
   end

   // Clear is edge sensitive, so a held pin clears only once.
   assign clearEvent = clockEnable && pinSync2_ff[0] && !clearPrev_ff;

   // Configuration registers.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            clearCode_ff[c] <= OSB_RST_CODE;
            slewCfg_ff[c] <= OSB_RST_SLEW;
            ctrl_ff[c] <= OSB_RST_CTRL;
            boostCfg_ff[c] <= OSB_RST_BOOST;
         end
      end else if (clockEnable && regWrite) begin
         unique case (grp)
            OSB_GRP_CLRCODE: clearCode_ff[chSel] <= regWrData[11:0];
            OSB_GRP_SLEW: slewCfg_ff[chSel] <= regWrData[7:0];
            OSB_GRP_CTRL: ctrl_ff[chSel] <= regWrData[1:0];
            OSB_GRP_BOOST: boostCfg_ff[chSel] <= regWrData[5:0];
            default: ;
         endcase
      end
   end

   // Read data stands in the cycle after the read strobe.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= 16'h0000;
      end else if (clockEnable) begin
         rdData_ff <= 16'h0000;
         if (regRead) begin
            unique case (grp)
               OSB_GRP_DATA: rdData_ff <= {4'h0, targetCode_ff[chSel]};
               OSB_GRP_CLRCODE: rdData_ff <= {4'h0, clearCode_ff[chSel]};
               OSB_GRP_SLEW: rdData_ff <= {8'h00, slewCfg_ff[chSel]};
               OSB_GRP_CTRL: rdData_ff <= {14'h0000, ctrl_ff[chSel]};
               OSB_GRP_BOOST: rdData_ff <= {10'h000, boostCfg_ff[chSel]};
               OSB_GRP_OUT: rdData_ff <= {4'h0, outCode_ff[chSel]};
               OSB_GRP_STATUS: rdData_ff <= {8'h00, busy, boost_limit_flag};
               default: rdData_ff <= 16'h0000;
            endcase
         end
      end
   end
   assign regRdData = rdData_ff;

   // One 64 kHz base tick shared by all channels; no register setting
   // reaches this path, so the tick rate is fixed by BASE_DIV.
   assign baseTick = clockEnable && (baseCnt_ff == 8'(BASE_DIV - 1));

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         baseCnt_ff <= 8'h00;
      end else if (clockEnable) begin
         baseCnt_ff <= baseTick ? 8'h00 : baseCnt_ff + 8'h01;
      end
   end

   // Per-channel divider down to the selected update rate.
   always_comb begin
      for (int c = 0; c < OSB_NCH; c++) begin
         chTick[c] = baseTick && (tickCnt_ff[c] >=
                     osbTickDiv(slewCfg_ff[c][OSB_SLEW_CLK_LSB +: 4]) - 1);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            tickCnt_ff[c] <= 17'h00000;
         end
      end else if (baseTick) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            tickCnt_ff[c] <= chTick[c] ? 17'h00000 : tickCnt_ff[c] + 17'h00001;
         end
      end
   end

   always_comb begin
      for (int c = 0; c < OSB_NCH; c++) begin
         busy[c] = slewCfg_ff[c][OSB_SLEW_EN_BIT] &&
                   (outCode_ff[c] != targetCode_ff[c]);
      end
   end
   assign anyBusy = |busy;

   // Target and output code for each channel.
   always_comb begin
      logic [12:0] diff;
      logic [8:0] step;
      logic slewOn;
      logic clrHit;
      diff = 13'h0000;
      step = 9'h001;
      slewOn = 1'b0;
      clrHit = 1'b0;
      for (int c = 0; c < OSB_NCH; c++) begin
         slewOn = slewCfg_ff[c][OSB_SLEW_EN_BIT];
         clrHit = clearEvent && ctrl_ff[c][OSB_CTRL_CLREN_BIT];
         nxt_target[c] = targetCode_ff[c];
         if (clockEnable && regWrite && grp == OSB_GRP_DATA &&
             chSel == 2'(c)) begin
            nxt_target[c] = regWrData[11:0];
         end else if (clrHit) begin
            nxt_target[c] = clearCode_ff[c];
         end
         nxt_outCode[c] = outCode_ff[c];
         step = osbStepSize(slewCfg_ff[c][OSB_SLEW_STEP_LSB +: 3]);
         if (!slewOn) begin
            nxt_outCode[c] = nxt_target[c];
         end else if (clrHit && anyBusy && !busy[c]) begin
            // An idle slewing channel jumps while another one is moving.
            nxt_outCode[c] = nxt_target[c];
         end else if (chTick[c] && outCode_ff[c] != targetCode_ff[c]) begin
            // Stepping starts from the present code toward the latest target.
            if (targetCode_ff[c] > outCode_ff[c]) begin
               diff = 13'(targetCode_ff[c] - outCode_ff[c]);
               nxt_outCode[c] = (diff <= 13'(step)) ? targetCode_ff[c]
                  : 12'(outCode_ff[c] + 12'(step));
            end else begin
               diff = 13'(outCode_ff[c] - targetCode_ff[c]);
               nxt_outCode[c] = (diff <= 13'(step)) ? targetCode_ff[c]
                  : 12'(outCode_ff[c] - 12'(step));
            end
         end
      end
   end

   // Every change, written or cleared, lands in the target first and the
   // stepper moves the output while slewing is on, except that a clear
   // makes an idle slewing channel jump while another one is moving.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            targetCode_ff[c] <= OSB_RST_CODE;
            outCode_ff[c] <= OSB_RST_CODE;
         end
      end else if (clockEnable) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            targetCode_ff[c] <= nxt_target[c];
            outCode_ff[c] <= nxt_outCode[c];
         end
      end
   end

   always_comb begin
      for (int c = 0; c < OSB_NCH; c++) begin
         outCode[c] = outCode_ff[c];
         outEnable[c] = ctrl_ff[c][OSB_CTRL_OUTEN_BIT];
         boostTargetDv[c] = bstTarget_ff[c];
         boostCeilingDv[c] =
            osbCeilDv(boostCfg_ff[c][OSB_BOOST_VMAX_LSB +: 2]);
         boost_limit_flag[c] = (bstState_ff[c] == OSB_BST_HOLD);
      end
   end
   assign switchGate = gate_ff;

   // Boost regulation target.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            bstTarget_ff[c] <= OSB_FLOOR_DV;
         end
      end else if (clockEnable) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            if (ctrl_ff[c][OSB_CTRL_OUTEN_BIT] &&
                loadNeedDv[c] + OSB_HEADROOM_DV > OSB_FLOOR_DV) begin
               bstTarget_ff[c] <= 9'(loadNeedDv[c] + OSB_HEADROOM_DV);
            end else begin
               bstTarget_ff[c] <= OSB_FLOOR_DV;
            end
         end
      end
   end

   // Ceiling hysteresis: hold stops switching until the decay comparator.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            bstState_ff[c] <= OSB_BST_RUN;
         end
      end else if (clockEnable) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            unique case (bstState_ff[c])
               OSB_BST_RUN: if (pinSync2_ff[1 + c]) begin
                  bstState_ff[c] <= OSB_BST_HOLD;
               end
               OSB_BST_HOLD: if (pinSync2_ff[5 + c] &&
                                 !pinSync2_ff[1 + c]) begin
                  bstState_ff[c] <= OSB_BST_RUN;
               end
            endcase
         end
      end
   end

   // Independent switching controllers with selectable period and phase.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            swCnt_ff[c] <= 6'h00;
            onCnt_ff[c] <= 6'h00;
         end
         gate_ff <= 4'h0;
      end else if (clockEnable) begin
         for (int c = 0; c < OSB_NCH; c++) begin
            logic [5:0] per;
            logic [5:0] phaseOff;
            logic [5:0] maxOn;
            per = osbSwPeriod(boostCfg_ff[c][OSB_BOOST_FREQ_LSB +: 2]);
            phaseOff = 6'((12'(per) *
                       12'(boostCfg_ff[c][OSB_BOOST_PHASE_LSB +: 2])) >> 2);
            maxOn = 6'((12'(per) * 12'(OSB_MAX_DUTY_PCT)) / 12'(100));
            swCnt_ff[c] <= (swCnt_ff[c] >= per - 6'h01) ? 6'h00
                           : swCnt_ff[c] + 6'h01;
            if (swCnt_ff[c] == phaseOff) begin
               // Pulses only while running, below target and not light.
               gate_ff[c] <= (bstState_ff[c] == OSB_BST_RUN) &&
                             pinSync2_ff[9 + c] &&
                             !pinSync2_ff[13 + c];
               onCnt_ff[c] <= 6'h00;
            end else if (gate_ff[c]) begin
               onCnt_ff[c] <= onCnt_ff[c] + 6'h01;
               if (pinSync2_ff[17 + c] ||
                   bstState_ff[c] == OSB_BST_HOLD ||
                   onCnt_ff[c] >= maxOn - 6'h01) begin
                  gate_ff[c] <= 1'b0;
               end
            end
         end
      end
   end
endmodule : osb_output_slew_boost

// File: include/osb_pkg.sv
// Constants, types and helpers for the output slew and boost control block.
package osb_pkg;
   localparam int OSB_NCH = 4;
   localparam int OSB_CODE_W = 12;
   localparam int OSB_DATA_W = 16;
   localparam int OSB_ADDR_W = 5;
   localparam int OSB_DV_W = 9;
   localparam int OSB_DIV_W = 17;
   localparam int OSB_SW_W = 6;

   // Register groups: address bits [4:2] pick the group, [1:0] the channel.
   localparam logic [2:0] OSB_GRP_DATA = 3'h0;
   localparam logic [2:0] OSB_GRP_CLRCODE = 3'h1;
   localparam logic [2:0] OSB_GRP_SLEW = 3'h2;
   localparam logic [2:0] OSB_GRP_CTRL = 3'h3;
   localparam logic [2:0] OSB_GRP_BOOST = 3'h4;
   localparam logic [2:0] OSB_GRP_OUT = 3'h5;
   localparam logic [2:0] OSB_GRP_STATUS = 3'h6;

   // Field positions.
   localparam int OSB_SLEW_EN_BIT = 0;
   localparam int OSB_SLEW_CLK_LSB = 1;
   localparam int OSB_SLEW_STEP_LSB = 5;
   localparam int OSB_CTRL_OUTEN_BIT = 0;
   localparam int OSB_CTRL_CLREN_BIT = 1;
   localparam int OSB_BOOST_VMAX_LSB = 0;
   localparam int OSB_BOOST_FREQ_LSB = 2;
   localparam int OSB_BOOST_PHASE_LSB = 4;
   localparam int OSB_STAT_BUSY_LSB = 4;

   // Reset values.
   localparam logic [11:0] OSB_RST_CODE = 12'h000;
   localparam logic [7:0] OSB_RST_SLEW = 8'h00;
   localparam logic [1:0] OSB_RST_CTRL = 2'h0;
   localparam logic [5:0] OSB_RST_BOOST = 6'h04;

   // Timing.
   localparam int OSB_CLK_HZ = 10_000_000;
   localparam int OSB_CLK_KHZ = OSB_CLK_HZ / 1000;
   localparam int OSB_BASE_TICK_HZ = 64_000;
   localparam int OSB_BASE_TICK_CYC = OSB_CLK_HZ / OSB_BASE_TICK_HZ;
   localparam int OSB_SW_KHZ_0 = 250;
   localparam int OSB_SW_KHZ_1 = 410;
   localparam int OSB_SW_KHZ_2 = 650;
   localparam int OSB_SW_KHZ_3 = 1000;
   localparam int OSB_MAX_DUTY_PCT = 90;

   // Boost voltages in units of 100 mV.
   localparam logic [8:0] OSB_FLOOR_DV = 9'h04a;
   localparam logic [8:0] OSB_HEADROOM_DV = 9'h014;
   localparam logic [8:0] OSB_VMAX0_DV = 9'h0e6;
   localparam logic [8:0] OSB_VMAX1_DV = 9'h0f5;
   localparam logic [8:0] OSB_VMAX2_DV = 9'h10e;
   localparam logic [8:0] OSB_VMAX3_DV = 9'h127;

   typedef enum logic [0:0] {
      OSB_BST_RUN = 1'b0,
      OSB_BST_HOLD = 1'b1
   } osb_bst_t;

   function automatic logic [8:0] osbStepSize(input logic [2:0] sel);
      logic [8:0] s;
      s = 9'h001;
      unique case (sel)
         3'h0: s = 9'h001;
         3'h1: s = 9'h002;
         3'h2: s = 9'h004;
         3'h3: s = 9'h010;
         3'h4: s = 9'h020;
         3'h5: s = 9'h040;
         3'h6: s = 9'h080;
         3'h7: s = 9'h100;
      endcase
      return s;
   endfunction : osbStepSize

   // Base ticks per update tick; the base tick runs at 64 kHz.
   function automatic logic [16:0] osbTickDiv(input logic [3:0] sel);
      logic [16:0] d;
      d = 17'h00001;
      unique case (sel)
         4'h0: d = 17'h00001;
         4'h1: d = 17'h00002;
         4'h2: d = 17'h00004;
         4'h3: d = 17'h00008;
         4'h4: d = 17'h00010;
         4'h5: d = 17'h00020;
         4'h6: d = 17'h00040;
         4'h7: d = 17'h00080;
         4'h8: d = 17'h00100;
         4'h9: d = 17'h00200;
         4'ha: d = 17'h003e8;
         4'hb: d = 17'h007d0;
         4'hc: d = 17'h00fa0;
         4'hd: d = 17'h01f40;
         4'he: d = 17'h03e80;
         4'hf: d = 17'h1f400;
      endcase
      return d;
   endfunction : osbTickDiv

   function automatic logic [5:0] osbSwPeriod(input logic [1:0] sel);
      logic [5:0] p;
      p = 6'(OSB_CLK_KHZ / OSB_SW_KHZ_1);
      unique case (sel)
         2'h0: p = 6'(OSB_CLK_KHZ / OSB_SW_KHZ_0);
         2'h1: p = 6'(OSB_CLK_KHZ / OSB_SW_KHZ_1);
         2'h2: p = 6'(OSB_CLK_KHZ / OSB_SW_KHZ_2);
         2'h3: p = 6'(OSB_CLK_KHZ / OSB_SW_KHZ_3);
      endcase
      return p;
   endfunction : osbSwPeriod

   function automatic logic [8:0] osbCeilDv(input logic [1:0] sel);
      logic [8:0] v;
      v = OSB_VMAX3_DV;
      unique case (sel)
         2'h0: v = OSB_VMAX0_DV;
         2'h1: v = OSB_VMAX1_DV;
         2'h2: v = OSB_VMAX2_DV;
         2'h3: v = OSB_VMAX3_DV;
      endcase
      return v;
   endfunction : osbCeilDv
endpackage : osb_pkg

// File: verification/osb_chk.sv
// Concurrent checks on the ports of the slew and boost control block.
`timescale 1ns/1ps
module osb_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clockEnable,
   // Register port.
   input wire logic [osb_pkg::OSB_ADDR_W-1:0] regAddr,
   input wire logic [osb_pkg::OSB_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   // Outputs and boost levels.
   input wire logic [3:0][osb_pkg::OSB_CODE_W-1:0] outCode,
   input wire logic [3:0] outEnable,
   input wire logic [3:0][osb_pkg::OSB_DV_W-1:0] loadNeedDv,
   input wire logic [3:0] boostAtCeiling,
   input wire logic [3:0] boostDecayed,
   input wire logic [3:0] lightLoad,
   input wire logic [3:0] switchCurrentLimit,
   input wire logic [3:0][osb_pkg::OSB_DV_W-1:0] boostTargetDv,
   input wire logic [3:0][osb_pkg::OSB_DV_W-1:0] boostCeilingDv,
   input wire logic [3:0] switchGate,
   input wire logic [3:0] boost_limit_flag
);
   import osb_pkg::*;
   logic [7:0] slew0_ff;
   logic [11:0] prev0_ff;
   logic [11:0] delta;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   function automatic logic [8:0] ceilOf(input logic [1:0] s);
      if (s == 2'h0) return OSB_VMAX0_DV;
      if (s == 2'h1) return OSB_VMAX1_DV;
      if (s == 2'h2) return OSB_VMAX2_DV;
      return OSB_VMAX3_DV;
   endfunction : ceilOf

   // Shadow of the channel 0 slew register, so stepping can be judged.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         slew0_ff <= OSB_RST_SLEW;
      end else if (clockEnable && regWrite && regAddr == 5'h08) begin
         slew0_ff <= regWrData[7:0];
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prev0_ff <= OSB_RST_CODE;
      end else begin
         prev0_ff <= outCode[0];
      end
   end
   assign delta = outCode[0] > prev0_ff ? outCode[0] - prev0_ff
                                        : prev0_ff - outCode[0];

   sequence atCeilLong;
      boostAtCeiling[0] [*4];
   endsequence
   sequence decayLong;
      (boostDecayed[0] && !boostAtCeiling[0]) [*4];
   endsequence

   a_direct_load: assert property (regWrite && regAddr == 5'h00 &&
      !slew0_ff[0] |=> outCode[0] == $past(regWrData[11:0]))
      else $error("direct code load missed");
   a_slew_step: assert property (slew0_ff[0] |->
      delta <= (slew0_ff[7:5] < 3'h3 ? 12'h001 << slew0_ff[7:5]
                                     : 12'h002 << slew0_ff[7:5]))
      else $error("slew step larger than programmed");
   a_ceil_sel: assert property (regWrite && regAddr[4:2] == OSB_GRP_BOOST
      |=> boostCeilingDv[$past(regAddr[1:0])] == ceilOf($past(regWrData[1:0])))
      else $error("boost ceiling does not follow selection");
   a_limit_set: assert property (atCeilLong |-> boost_limit_flag[0])
      else $error("limit flag not set at ceiling");
   a_limit_clear: assert property (decayLong |-> !boost_limit_flag[0])
      else $error("limit flag not cleared after decay");
   a_hold_gate: assert property (
      (boost_limit_flag & $past(boost_limit_flag) & switchGate) == 4'h0)
      else $error("switching while held at ceiling");
   a_gate_limit: assert property ((switchCurrentLimit & $past(switchGate) &
      $past(switchCurrentLimit, 1) & $past(switchCurrentLimit, 2) &
      $past(switchCurrentLimit, 3) & switchGate) == 4'h0)
      else $error("pulse not ended by current limit");
   a_light_skip: assert property ((lightLoad & ~$past(switchGate) &
      $past(lightLoad, 1) & $past(lightLoad, 2) & $past(lightLoad, 3) &
      switchGate) == 4'h0)
      else $error("pulse started at light load");
   a_target_floor: assert property (!outEnable[0] && !$past(outEnable[0])
      |-> boostTargetDv[0] == OSB_FLOOR_DV)
      else $error("disabled target is not the floor");
   a_target_need: assert property (outEnable[0] && $past(outEnable[0]) &&
      $stable(loadNeedDv[0]) |-> boostTargetDv[0] ==
      (loadNeedDv[0] + OSB_HEADROOM_DV > OSB_FLOOR_DV ?
       loadNeedDv[0] + OSB_HEADROOM_DV : OSB_FLOOR_DV))
      else $error("enabled target is wrong");
endmodule : osb_chk

bind osb_output_slew_boost osb_chk u_chk (.*);

// File: verification/osb_analog_model.sv
// Behavioural model of the four output stages and their boost supplies.
`timescale 1ns/1ps
module osb_analog_model (
   // Clock, reset and pace of the supply ramp.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic slow,
   // From the digital block.
   input wire logic [3:0][osb_pkg::OSB_CODE_W-1:0] outCode,
   input wire logic [3:0][osb_pkg::OSB_DV_W-1:0] boostCeilingDv,
   input wire logic [3:0][osb_pkg::OSB_DV_W-1:0] boostTargetDv,
   input wire logic [3:0] switchGate,
   // Sensed levels back to the block.
   output logic [3:0][osb_pkg::OSB_DV_W-1:0] loadNeedDv,
   output logic [3:0] boostAtCeiling,
   output logic [3:0] boostDecayed,
   output logic [3:0] boostBelowTarget,
   output logic [3:0] lightLoad,
   output logic [3:0] switchCurrentLimit
);
   import osb_pkg::*;
   int vDv [4];
   int onCyc [4];
   int tickCnt;
   // Each supply is separate; the slow pace stands for a heavy load.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         vDv <= '{default: 0};
         onCyc <= '{default: 0};
         tickCnt <= 0;
         loadNeedDv <= '0;
         boostAtCeiling <= 4'h0;
         boostDecayed <= 4'h0;
         boostBelowTarget <= 4'h0;
         lightLoad <= 4'h0;
         switchCurrentLimit <= 4'h0;
      end else begin
         tickCnt <= tickCnt + 1;
         for (int c = 0; c < 4; c++) begin
            if (switchGate[c]) begin
               vDv[c] <= vDv[c] + (slow ? 2 : 4);
               onCyc[c] <= onCyc[c] + 1;
            end else begin
               onCyc[c] <= 0;
               if (tickCnt % 4 == 0 && vDv[c] > 0) begin
                  vDv[c] <= vDv[c] - 1;
               end
            end
            loadNeedDv[c] <= {1'b0, outCode[c][11:4]};
            boostAtCeiling[c] <= vDv[c] >= int'(boostCeilingDv[c]);
            boostDecayed[c] <= vDv[c] <= int'(boostCeilingDv[c]) - 4;
            boostBelowTarget[c] <= vDv[c] < int'(boostTargetDv[c]);
            lightLoad[c] <= outCode[c] < 12'h040;
            switchCurrentLimit[c] <= onCyc[c] >= 6;
         end
      end
   end
endmodule : osb_analog_model

// File: verification/output_slew_and_boost_control_bench.sv
// Self-checking bench for the slew and boost control block.
`timescale 1ns/1ps
module output_slew_and_boost_control_bench;
   import osb_pkg::*;
   typedef struct packed {
      logic wr;
      logic [4:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } osb_row_t;
   localparam int BDIV = 2;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic clockEnable = 1'b1;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic clearPin = 1'b0;
   logic slow = 1'b0;
   logic [15:0] regRdData;
   logic [3:0][11:0] outCode;
   logic [3:0] outEnable, switchGate, boost_limit_flag, boostAtCeiling;
   logic [3:0] boostDecayed, boostBelowTarget, lightLoad, switchCurrentLimit;
   logic [3:0][8:0] loadNeedDv, boostTargetDv, boostCeilingDv;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   // Register rows: reset reads first, then write and read back.
   osb_row_t rows [11] = '{'{1'b0, 5'h00, 16'h0000, 16'h0000},
      '{1'b0, 5'h08, 16'h0000, 16'h0000}, '{1'b0, 5'h0c, 16'h0000, 16'h0000},
      '{1'b0, 5'h10, 16'h0000, 16'h0004}, '{1'b1, 5'h01, 16'hfabc, 16'h0abc},
      '{1'b1, 5'h06, 16'h1234, 16'h0234}, '{1'b1, 5'h0b, 16'hffff, 16'h00ff},
      '{1'b1, 5'h0d, 16'hffff, 16'h0003}, '{1'b1, 5'h11, 16'hffff, 16'h003f},
      '{1'b1, 5'h15, 16'h0fff, 16'h0abc}, '{1'b1, 5'h1c, 16'hffff, 16'h0000}};
   logic [15:0] steps [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010,
      16'h0020, 16'h0040, 16'h0080, 16'h0100};
   logic [3:0] sels [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb};
   logic [15:0] divs [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
      16'h0010, 16'h0200, 16'h03e8, 16'h07d0};
   logic [15:0] ceils [4] = '{16'h00e6, 16'h00f5, 16'h010e, 16'h0127};

   osb_output_slew_boost #(.BASE_DIV(BDIV)) DUT (.*);
   osb_analog_model model (.*);

   always #50 clock = ~clock;

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // A hung wait must still end in the closing report.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      chk("read data", regRdData, e);
   endtask : rd

   // Waits, with a bound, until the channel 0 code moves.
   task automatic waitChg(output int k);
      logic [11:0] p;
      p = outCode[0];
      k = 0;
      while (outCode[0] === p && k < 9000) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask : waitChg

   task automatic go(input logic [11:0] c);
      wr(5'h08, 16'h0000);
      wr(5'h00, {4'h0, c});
   endtask : go

   task automatic waitFlag(input logic v);
      int k;
      k = 0;
      while (boost_limit_flag[0] !== v && k < 5000) begin
         @(posedge clock);
         #1;
         k++;
      end
      chk("limit flag", {15'h0, boost_limit_flag[0]}, {15'h0, v});
   endtask : waitFlag

   initial begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].a, rows[i].d);
         end
         rd(rows[i].a, rows[i].e);
      end
      for (int s = 0; s < 8; s++) begin
         go(12'h000);
         wr(5'h08, {8'h00, 3'(s), 5'h01});
         wr(5'h00, steps[s] + 16'h0001);
         waitChg(n);
         chk("first step", {4'h0, outCode[0]}, steps[s]);
         waitChg(n);
         chk("last step", {4'h0, outCode[0]}, steps[s] + 16'h0001);
         repeat (8) @(posedge clock);
         chk("stopped", {4'h0, outCode[0]}, steps[s] + 16'h0001);
      end
      for (int i = 0; i < 8; i++) begin
         go(12'h000);
         wr(5'h08, {11'h000, sels[i], 1'b1});
         wr(5'h00, 16'h0003);
         waitChg(n);
         waitChg(n);
         chk("tick period", 16'(n), 16'(BDIV) * divs[i]);
      end
      go(12'h000);
      wr(5'h08, 16'h0069);
      wr(5'h00, 16'h0100);
      waitChg(n);
      waitChg(n);
      wr(5'h00, 16'h0010);
      waitChg(n);
      chk("retarget", {4'h0, outCode[0]}, 16'h0010);
      wr(5'h0d, 16'h0001);
      wr(5'h0e, 16'h0002);
      wr(5'h04, 16'h0040);
      wr(5'h0c, 16'h0002);
      go(12'h000);
      wr(5'h08, 16'h0069);
      @(posedge clock);
      clearPin <= 1'b1;
      repeat (3) @(posedge clock);
      clearPin <= 1'b0;
      waitChg(n);
      chk("clear step", {4'h0, outCode[0]}, 16'h0010);
      chk("clear direct", {4'h0, outCode[2]}, 16'h0234);
      chk("clear off", {4'h0, outCode[1]}, 16'h0abc);
      repeat (160) @(posedge clock);
      chk("clear end", {4'h0, outCode[0]}, 16'h0040);
      for (int v = 0; v < 4; v++) begin
         wr(5'h10, {14'h0001, 2'(v)});
         chk("ceiling", {7'h00, boostCeilingDv[0]}, ceils[v]);
      end
      for (int k = 0; k < 2; k++) begin
         slow <= k[0];
         go(12'hfff);
         wr(5'h0c, 16'h0001);
         wr(5'h10, 16'h0004);
         waitFlag(1'b1);
         rd(5'h18, 16'h0001);
         waitFlag(1'b0);
         waitFlag(1'b1);
      end
      // A second reset in mid-run must bring the control register back.
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      rd(5'h0c, 16'h0000);
      report_and_stop();
   end
endmodule : output_slew_and_boost_control_bench
